// file: tb/tee_host_model.sv
// Host model that sends register writes and reads to the timing block.
`timescale 1ns/10ps
module tee_host_model (
    input wire logic clk_i,
    input wire logic [tee_pkg::TEE_DATA_W-1:0] rd_data_i,
    output tee_pkg::tee_reg_req_t req_o
);
    import tee_pkg::*;

    initial req_o = '0;

    // Released address and data lines carry the inverse so a stale value never passes.
    task automatic write_reg(input logic [7:0] addr, input logic [23:0] data);
        logic [23:0] d;
        d = data;
        if (addr == TEE_OFS_TIMING_CLOCK_DIVIDER && d[2:0] inside {3'h1, 3'h2, 3'h3}) begin
            d[2:0] = TEE_DIV_BY1;
        end
        @(posedge clk_i);
        req_o <= '{wr: 1'h1, rd: 1'h0, addr: addr, wdata: d};
        @(posedge clk_i);
        req_o <= '{wr: 1'h0, rd: 1'h0, addr: ~addr, wdata: ~d};
    endtask

    task automatic read_reg(input logic [7:0] addr, output logic [23:0] data);
        @(posedge clk_i);
        req_o <= '{wr: 1'h0, rd: 1'h1, addr: addr, wdata: 24'h0};
        @(posedge clk_i);
        req_o <= '{wr: 1'h0, rd: 1'h0, addr: ~addr, wdata: 24'hffffff};
        @(posedge clk_i);
        data = rd_data_i;
    endtask
endmodule

// file: tb/test_tee_timing_extra.sv
// Self-checking testbench for the extra timing-phase register block.
`timescale 1ns/10ps
module test_tee_timing_extra;
    import tee_pkg::*;

    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic ce_i = 1'h1;
    logic conv_tick_i = 1'h0;
    logic count_clear_i = 1'h0;
    logic conv_ready_i = 1'h0;
    logic ready_sel_i = 1'h0;
    tee_reg_req_t reg_req;
    logic [23:0] rd_data;
    logic [15:0] count;
    logic tick, prog_out, led3_on, ready;
    int n_fail = 0;
    int checks = 0;
    int phase = 0;
    int conv_cnt = 0;
    bit mon_on = 0;
    logic exp_p, exp_l, prev_p, prev_rdy, prev_sel, prev_tick, prev_clr;
    logic [15:0] prev_cnt, ps, pe, ls, le;

    tee_timing_extra uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .reg_req_i(reg_req),
        .rd_data_o(rd_data), .conv_tick_i(conv_tick_i), .count_clear_i(count_clear_i),
        .conv_ready_i(conv_ready_i), .ready_sel_i(ready_sel_i), .count_o(count),
        .timing_tick_o(tick), .prog_out_o(prog_out), .led3_on_o(led3_on), .ready_o(ready));

    tee_host_model host (.clk_i(clk_i), .rd_data_i(rd_data), .req_o(reg_req));

    always #50 clk_i = ~clk_i;

    // Converter ticks come 2 of every 5 cycles, as a 4 MHz clock seen from 10 MHz.
    always @(posedge clk_i) begin
        phase <= (phase + 1) % 5;
        conv_tick_i <= (phase == 4) || (phase == 1);
        conv_ready_i <= phase[1];
        if (conv_tick_i && ce_i) begin
            conv_cnt <= conv_cnt + 1;
        end
    end

    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic conclude();
        if (n_fail == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Output monitor
    // ------------------------------------------------------------------
    // Levels follow the count seen on each tick, before its increment; end beats start.
    always @(negedge clk_i) begin
        if (mon_on) begin
            check("prog_out", {23'h0, exp_p}, {23'h0, prog_out});
            check("led3_on", {23'h0, exp_l}, {23'h0, led3_on});
            check("ready", {23'h0, prev_sel ? prev_p : prev_rdy}, {23'h0, ready});
            if (prev_tick && !prev_clr) check("count", {8'h0, prev_cnt + 16'h1}, {8'h0, count});
            if (tick) begin
                exp_p = (count == pe) ? 1'h0 : (count == ps) ? 1'h1 : exp_p;
                exp_l = (count == le) ? 1'h0 : (count == ls) ? 1'h1 : exp_l;
            end
        end
        prev_p = prog_out;
        prev_rdy = conv_ready_i;
        prev_sel = ready_sel_i;
        prev_tick = tick;
        prev_clr = count_clear_i;
        prev_cnt = count;
    end

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic regs_case();
        logic [7:0] ofs [6] = '{8'h34, 8'h35, 8'h36, 8'h37, 8'h39, 8'h38};
        logic [23:0] d;
        check("outs", 24'h0, {count, tick, prog_out, led3_on, ready});
        foreach (ofs[i]) begin
            host.read_reg(ofs[i], d);
            check("reset_read", 24'h0, d);
        end
        host.write_reg(TEE_OFS_THIRD_LED_PHASE_START, 24'habcdef);
        host.read_reg(TEE_OFS_THIRD_LED_PHASE_START, d);
        check("led3_start", 24'h00cdef, d);
        host.write_reg(TEE_OFS_THIRD_LED_PHASE_END, 24'h12cdef);
        host.read_reg(TEE_OFS_THIRD_LED_PHASE_END, d);
        check("led3_end", 24'h00cdef, d);
        host.write_reg(TEE_OFS_PROG_OUTPUT_START, 24'h001234);
        host.write_reg(TEE_OFS_PROG_OUTPUT_END, 24'h001234);
        host.read_reg(TEE_OFS_PROG_OUTPUT_START, d);
        check("prog_start_rd", 24'h0, d);
        host.read_reg(TEE_OFS_PROG_OUTPUT_END, d);
        check("prog_end_rd", 24'h0, d);
        host.write_reg(8'h38, 24'h00ffff);
        host.read_reg(8'h38, d);
        check("unmapped", 24'h0, d);
    endtask

    task automatic div_case(input logic [2:0] code, input int ratio);
        int seen, last;
        logic [23:0] d;
        host.write_reg(TEE_OFS_TIMING_CLOCK_DIVIDER, {21'h0, code});
        host.read_reg(TEE_OFS_TIMING_CLOCK_DIVIDER, d);
        check("div_sel", {21'h0, code}, d);
        seen = 0;
        last = 0;
        for (int k = 0; k < 400 && seen < 4; k++) begin
            @(negedge clk_i);
            if (tick) begin
                if (seen >= 2) check("tick_spacing", 24'(ratio), 24'(conv_cnt - last));
                last = conv_cnt;
                seen++;
            end
        end
        if (seen < 4) begin
            check("tick_count", 24'h4, 24'(seen));
            conclude();
        end
    endtask

    task automatic phase_case();
        ps = 16'h3;
        pe = 16'h7;
        ls = 16'h1;
        le = 16'h5;
        host.write_reg(TEE_OFS_TIMING_CLOCK_DIVIDER, {21'h0, TEE_DIV_BY4});
        host.write_reg(TEE_OFS_PROG_OUTPUT_START, {8'h0, ps});
        host.write_reg(TEE_OFS_PROG_OUTPUT_END, {8'h0, pe});
        host.write_reg(TEE_OFS_THIRD_LED_PHASE_START, {8'h0, ls});
        host.write_reg(TEE_OFS_THIRD_LED_PHASE_END, {8'h0, le});
        @(posedge clk_i);
        count_clear_i <= 1'h1;
        ready_sel_i <= 1'h1;
        @(posedge clk_i);
        count_clear_i <= 1'h0;
        @(posedge clk_i);
        exp_p = 1'h0;
        exp_l = 1'h0;
        mon_on = 1;
        repeat (100) @(posedge clk_i);
        ready_sel_i <= 1'h0;
        repeat (100) @(posedge clk_i);
        mon_on = 0;
        check("count_span", 24'h1, {23'h0, count > 16'hc});
    endtask

    // A write issued while the enable is low must be lost and nothing may move.
    task automatic freeze_case();
        logic [23:0] d, snap;
        @(posedge clk_i);
        ce_i <= 1'h0;
        @(negedge clk_i);
        snap = {count, tick, prog_out, led3_on, ready};
        host.write_reg(TEE_OFS_THIRD_LED_PHASE_START, 24'h000055);
        repeat (20) begin
            @(negedge clk_i);
            check("frozen", snap, {count, tick, prog_out, led3_on, ready});
        end
        @(posedge clk_i);
        ce_i <= 1'h1;
        host.read_reg(TEE_OFS_THIRD_LED_PHASE_START, d);
        check("frozen_wr", {8'h0, ls}, d);
    endtask

    task automatic reset_case();
        logic [23:0] d;
        @(posedge clk_i);
        rst_i <= 1'h1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        @(negedge clk_i);
        check("rst_outs", 24'h0, {count, tick, prog_out, led3_on, ready});
        host.read_reg(TEE_OFS_TIMING_CLOCK_DIVIDER, d);
        check("rst_div", 24'h0, d);
        host.read_reg(TEE_OFS_THIRD_LED_PHASE_END, d);
        check("rst_led3_end", 24'h0, d);
    endtask

    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'h0;
        regs_case();
        div_case(TEE_DIV_BY1, 1);
        div_case(TEE_DIV_BY2, 2);
        div_case(TEE_DIV_BY4, 4);
        div_case(TEE_DIV_BY8, 8);
        div_case(TEE_DIV_BY16, 16);
        phase_case();
        freeze_case();
        reset_case();
        conclude();
    end
endmodule

// file: verilog/tee_pkg.sv
// Package of shared constants, types and decode helpers for the extra timing-phase block.
package tee_pkg;

    // ------------------------------------------------------------------
    // Register offsets and widths
    // ------------------------------------------------------------------
    localparam logic [7:0] TEE_OFS_PROG_OUTPUT_START = 8'h34;
    localparam logic [7:0] TEE_OFS_PROG_OUTPUT_END = 8'h35;
    localparam logic [7:0] TEE_OFS_THIRD_LED_PHASE_START = 8'h36;
    localparam logic [7:0] TEE_OFS_THIRD_LED_PHASE_END = 8'h37;
    localparam logic [7:0] TEE_OFS_TIMING_CLOCK_DIVIDER = 8'h39;

    localparam int TEE_ADDR_W = 8;
    localparam int TEE_DATA_W = 24;
    localparam int TEE_COUNT_W = 16;
    localparam int TEE_DIVSEL_W = 3;
    localparam int TEE_DIVCNT_W = 4;

    // ------------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------------
    localparam logic [15:0] TEE_COUNT_RST = 16'h0000;
    localparam logic [2:0] TEE_DIVSEL_RST = 3'h0;
    localparam logic [23:0] TEE_RDATA_RST = 24'h000000;
    localparam int TEE_COUNT_LSB = 0;
    localparam int TEE_DIVSEL_LSB = 0;

    // ------------------------------------------------------------------
    // Clock rates
    // ------------------------------------------------------------------
    localparam int TEE_CLK_HZ = 10000000;
    localparam int TEE_CONV_CLK_HZ = 4000000;

    // ------------------------------------------------------------------
    // Divider codes
    // ------------------------------------------------------------------
    localparam logic [2:0] TEE_DIV_BY1 = 3'h0;
    localparam logic [2:0] TEE_DIV_BY2 = 3'h4;
    localparam logic [2:0] TEE_DIV_BY4 = 3'h5;
    localparam logic [2:0] TEE_DIV_BY8 = 3'h6;
    localparam logic [2:0] TEE_DIV_BY16 = 3'h7;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [23:0] wdata;
    } tee_reg_req_t;

    // Terminal count of the converter-tick counter, ratio minus one.
    // Forbidden codes fall back to divide by one so the engine never stalls.
    function automatic logic [3:0] tee_div_last(input logic [2:0] sel);
        logic [3:0] last;
        last = 4'h0;
        case (sel)
            TEE_DIV_BY2: last = 4'h1;
            TEE_DIV_BY4: last = 4'h3;
            TEE_DIV_BY8: last = 4'h7;
            TEE_DIV_BY16: last = 4'hf;
            default: last = 4'h0;
        endcase
        return last;
    endfunction

    // True for offsets whose fields read back as zero.
    function automatic logic tee_is_write_only(input logic [7:0] addr);
        return (addr == TEE_OFS_PROG_OUTPUT_START) || (addr == TEE_OFS_PROG_OUTPUT_END);
    endfunction

endpackage

// file: verilog/tee_tclk_div.sv
// Timing-clock divider: turns converter-clock ticks into timing-engine ticks.
`timescale 1ns/10ps
module tee_tclk_div (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic conv_tick_i,
    input wire logic [tee_pkg::TEE_DIVSEL_W-1:0] div_sel_i,
    output logic tick_o
);
    import tee_pkg::*;

    logic [TEE_DIVCNT_W-1:0] cnt_ff;
    logic tick_ff;
    logic [TEE_DIVCNT_W-1:0] last;

    assign last = tee_div_last(div_sel_i);
    assign tick_o = tick_ff;

    // ------------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------------
    // A shortened ratio takes effect at once because the count compares with >=.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_ff <= 4'h0;
            tick_ff <= 1'b0;
        end else if (ce_i) begin
            tick_ff <= 1'b0;
            if (conv_tick_i) begin
                if (cnt_ff >= last) begin
                    cnt_ff <= 4'h0;
                    tick_ff <= 1'b1;
                end else begin
                    cnt_ff <= cnt_ff + 4'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_div_one;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && conv_tick_i && (div_sel_i == TEE_DIV_BY1) |=> tick_o;
    endproperty
    a_div_one: assert property (p_div_one) else $error("Divide by one missed a tick.");

    property p_div_source;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && !conv_tick_i |=> !tick_o;
    endproperty
    a_div_source: assert property (p_div_source) else $error("Tick without converter tick.");

    // The first converter tick of a divide-by-two pair must not produce a tick.
    property p_div_two;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && conv_tick_i && (div_sel_i == TEE_DIV_BY2) && (cnt_ff == 4'h0) |=> !tick_o;
    endproperty
    a_div_two: assert property (p_div_two) else $error("Divide by two ticked early.");
endmodule

// file: verilog/tee_timing_extra.sv
// Extra phase registers of the timing engine: programmable output, third LED phase, divider.
//
// Functional notes
// - Programmable output rises at its start count.
// - Programmable output falls at its end count.
// - Programmable output counts are write-only.
// - Third LED on-phase begins at start count.
// - Third LED on-phase ends at end count.
// - Divider codes 0,4,5,6,7 give 1..16.
// - Timing clock is converter clock over ratio.
// - All these registers reset to zero.
`timescale 1ns/10ps
module tee_timing_extra (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire tee_pkg::tee_reg_req_t reg_req_i,
    output logic [tee_pkg::TEE_DATA_W-1:0] rd_data_o,
    input wire logic conv_tick_i,
    input wire logic count_clear_i,
    input wire logic conv_ready_i,
    input wire logic ready_sel_i,
    output logic [tee_pkg::TEE_COUNT_W-1:0] count_o,
    output logic timing_tick_o,
    output logic prog_out_o,
    output logic led3_on_o,
    output logic ready_o
);
    import tee_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [TEE_COUNT_W-1:0] prog_output_start_count_ff;
    logic [TEE_COUNT_W-1:0] prog_output_end_count_ff;
    logic [TEE_COUNT_W-1:0] third_led_on_start_ff;
    logic [TEE_COUNT_W-1:0] third_led_on_end_ff;
    logic [TEE_DIVSEL_W-1:0] timing_clock_div_sel_ff;
    logic [TEE_DATA_W-1:0] rd_data_ff;
    logic [TEE_COUNT_W-1:0] count_ff;
    logic prog_out_ff;
    logic led3_on_ff;
    logic ready_ff;
    logic tick;
    logic [TEE_DATA_W-1:0] nxt_rd_data;

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    // Bits 23..16 (and 23..3 of the divider) must be written as zero and are
    // simply not stored, so they can never disturb a count.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prog_output_start_count_ff <= TEE_COUNT_RST;
            prog_output_end_count_ff <= TEE_COUNT_RST;
            third_led_on_start_ff <= TEE_COUNT_RST;
            third_led_on_end_ff <= TEE_COUNT_RST;
            timing_clock_div_sel_ff <= TEE_DIVSEL_RST;
        end else if (ce_i && reg_req_i.wr) begin
            unique case (reg_req_i.addr)
                TEE_OFS_PROG_OUTPUT_START: begin
                    prog_output_start_count_ff <=
                        reg_req_i.wdata[TEE_COUNT_LSB +: TEE_COUNT_W];
                end
                TEE_OFS_PROG_OUTPUT_END: begin
                    prog_output_end_count_ff <=
                        reg_req_i.wdata[TEE_COUNT_LSB +: TEE_COUNT_W];
                end
                TEE_OFS_THIRD_LED_PHASE_START: begin
                    third_led_on_start_ff <= reg_req_i.wdata[TEE_COUNT_LSB +: TEE_COUNT_W];
                end
                TEE_OFS_THIRD_LED_PHASE_END: begin
                    third_led_on_end_ff <= reg_req_i.wdata[TEE_COUNT_LSB +: TEE_COUNT_W];
                end
                TEE_OFS_TIMING_CLOCK_DIVIDER: begin
                    timing_clock_div_sel_ff <=
                        reg_req_i.wdata[TEE_DIVSEL_LSB +: TEE_DIVSEL_W];
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------------
    always_comb begin
        nxt_rd_data = TEE_RDATA_RST;
        if (tee_is_write_only(reg_req_i.addr)) begin
            nxt_rd_data = TEE_RDATA_RST;
        end else if (reg_req_i.addr == TEE_OFS_THIRD_LED_PHASE_START) begin
            nxt_rd_data = {8'h00, third_led_on_start_ff};
        end else if (reg_req_i.addr == TEE_OFS_THIRD_LED_PHASE_END) begin
            nxt_rd_data = {8'h00, third_led_on_end_ff};
        end else if (reg_req_i.addr == TEE_OFS_TIMING_CLOCK_DIVIDER) begin
            nxt_rd_data = {21'h000000, timing_clock_div_sel_ff};
        end
    end

    // Read data holds until the next read so a slow serial engine can shift it out.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_data_ff <= TEE_RDATA_RST;
        end else if (ce_i && reg_req_i.rd) begin
            rd_data_ff <= nxt_rd_data;
        end
    end

    assign rd_data_o = rd_data_ff;

    // ------------------------------------------------------------------
    // Timing clock
    // ------------------------------------------------------------------
    tee_tclk_div u_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .conv_tick_i(conv_tick_i),
        .div_sel_i(timing_clock_div_sel_ff),
        .tick_o(tick)
    );

    // ------------------------------------------------------------------
    // Shared counter
    // ------------------------------------------------------------------
    // The period is owned by the rest of the engine, which clears the count.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_ff <= TEE_COUNT_RST;
        end else if (ce_i) begin
            if (count_clear_i) begin
                count_ff <= TEE_COUNT_RST;
            end else if (tick) begin
                count_ff <= count_ff + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------------
    // Phase outputs
    // ------------------------------------------------------------------
    // The end match wins over the start match, so all-zero counts keep a
    // phase off; that is why an unused third LED is programmed to zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prog_out_ff <= 1'b0;
        end else if (ce_i && tick) begin
            if (count_ff == prog_output_end_count_ff) begin
                prog_out_ff <= 1'b0;
            end else if (count_ff == prog_output_start_count_ff) begin
                prog_out_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            led3_on_ff <= 1'b0;
        end else if (ce_i && tick) begin
            if (count_ff == third_led_on_end_ff) begin
                led3_on_ff <= 1'b0;
            end else if (count_ff == third_led_on_start_ff) begin
                led3_on_ff <= 1'b1;
            end
        end
    end

    // The programmable signal may stand in for the conversion-ready output.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ready_ff <= 1'b0;
        end else if (ce_i) begin
            ready_ff <= ready_sel_i ? prog_out_ff : conv_ready_i;
        end
    end

    assign count_o = count_ff;
    assign timing_tick_o = tick;
    assign prog_out_o = prog_out_ff;
    assign led3_on_o = led3_on_ff;
    assign ready_o = ready_ff;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_prog_rise;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && tick && (count_ff == prog_output_start_count_ff)
            && (count_ff != prog_output_end_count_ff) |=> prog_out_o;
    endproperty
    a_prog_rise: assert property (p_prog_rise) else $error("Output did not rise at start.");

    property p_prog_fall;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && tick && (count_ff == prog_output_end_count_ff) |=> !prog_out_o;
    endproperty
    a_prog_fall: assert property (p_prog_fall) else $error("Output did not fall at end.");

    property p_wo_read;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && reg_req_i.rd && tee_is_write_only(reg_req_i.addr) |=> (rd_data_o == 24'h000000);
    endproperty
    a_wo_read: assert property (p_wo_read) else $error("Write-only field read nonzero.");

    property p_led3_rise;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && tick && (count_ff == third_led_on_start_ff)
            && (count_ff != third_led_on_end_ff) |=> led3_on_o;
    endproperty
    a_led3_rise: assert property (p_led3_rise) else $error("LED phase did not start.");

    property p_led3_fall;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && tick && (count_ff == third_led_on_end_ff) |=> !led3_on_o;
    endproperty
    a_led3_fall: assert property (p_led3_fall) else $error("LED phase did not end.");

    property p_div_readback;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && reg_req_i.wr && (reg_req_i.addr == TEE_OFS_TIMING_CLOCK_DIVIDER)
            ##1 ce_i && !reg_req_i.wr
            ##1 ce_i && reg_req_i.rd && !reg_req_i.wr
            && (reg_req_i.addr == TEE_OFS_TIMING_CLOCK_DIVIDER)
            |=> (rd_data_o[2:0] == $past(reg_req_i.wdata[2:0], 3));
    endproperty
    a_div_readback: assert property (p_div_readback) else $error("Divider readback wrong.");

    property p_reset_zero;
        @(posedge clk_i)
        rst_i |=> (count_o == 16'h0000) && !prog_out_o && !led3_on_o
            && (timing_clock_div_sel_ff == 3'h0) && (third_led_on_start_ff == 16'h0000);
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("State not zero after reset.");

    property p_count_step;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && tick && !count_clear_i |=> (count_o == $past(count_o) + 16'h0001);
    endproperty
    a_count_step: assert property (p_count_step) else $error("Count did not advance.");

    property p_count_hold;
        @(posedge clk_i) disable iff (rst_i)
        !ce_i |=> $stable(count_o) && $stable(prog_out_o) && $stable(led3_on_o);
    endproperty
    a_count_hold: assert property (p_count_hold) else $error("State moved with enable low.");

    property p_freeze_out;
        @(posedge clk_i) disable iff (rst_i)
        !ce_i |=> $stable(rd_data_o) && $stable(ready_o) && $stable(timing_tick_o);
    endproperty
    a_freeze_out: assert property (p_freeze_out) else $error("Output moved with enable low.");

    property p_rst_rest;
        @(posedge clk_i)
        rst_i |=> !ready_o && !timing_tick_o && (rd_data_o == 24'h000000)
            && (prog_output_start_count_ff == 16'h0000) && (prog_output_end_count_ff == 16'h0000)
            && (third_led_on_end_ff == 16'h0000);
    endproperty
    a_rst_rest: assert property (p_rst_rest) else $error("Register not zero after reset.");

    property p_ready_prog;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && ready_sel_i |=> (ready_o == $past(prog_out_o));
    endproperty
    a_ready_prog: assert property (p_ready_prog) else $error("Ready did not follow output.");

    property p_ready_conv;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && !ready_sel_i |=> (ready_o == $past(conv_ready_i));
    endproperty
    a_ready_conv: assert property (p_ready_conv) else $error("Ready did not follow native.");

    property p_led3_start_read;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && reg_req_i.rd && (reg_req_i.addr == TEE_OFS_THIRD_LED_PHASE_START)
            |=> (rd_data_o == {8'h00, $past(third_led_on_start_ff)});
    endproperty
    a_led3_start_read: assert property (p_led3_start_read) else $error("LED start readback wrong.");

    property p_led3_end_read;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && reg_req_i.rd && (reg_req_i.addr == TEE_OFS_THIRD_LED_PHASE_END)
            |=> (rd_data_o == {8'h00, $past(third_led_on_end_ff)});
    endproperty
    a_led3_end_read: assert property (p_led3_end_read) else $error("LED end readback wrong.");

    // An unused third LED, programmed to zero at both ends, must never light.
    property p_led3_unused;
        @(posedge clk_i) disable iff (rst_i)
        (third_led_on_start_ff == 16'h0000) && (third_led_on_end_ff == 16'h0000)
            && !led3_on_o |=> !led3_on_o;
    endproperty
    a_led3_unused: assert property (p_led3_unused) else $error("Unused LED phase lit.");

    property p_count_clear;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && count_clear_i |=> (count_o == 16'h0000);
    endproperty
    a_count_clear: assert property (p_count_clear) else $error("Count not cleared.");

    property p_phase_hold;
        @(posedge clk_i) disable iff (rst_i)
        ce_i && !tick |=> $stable(prog_out_o) && $stable(led3_on_o);
    endproperty
    a_phase_hold: assert property (p_phase_hold) else $error("Phase moved without a tick.");
endmodule
